// ==== rtl/rlcis_top.sv ====
// rlcis_top: turbo coding, frame interleaving, mapping, spreading and scrambling
`timescale 1ns/1ns
`include "rlcis_params.svh"
// Function
// - random-access frames use rate 1/3 turbo code, two 8-state encoders.
// - dedicated frames reuse the turbo encoder, punctured to rate 1/2.
// - keep systematic; first parity on even steps, second parity on odd.
// - puncture information bits only; tail bits pass whole.
// - interleave random-access always, mobile dedicated on mobile terminals only.
// - interleave one frame's coded bits; unique word stays out.
// - thirty columns at rate one third, sixteen at rate one half.
// - row count is the least with rows times columns covering the bits.
// - fill the matrix row by row from row 0 column 0, pad dummies.
// - sixteen-column reorder 0,8,4,12,2,10,6,14,1,9,5,13,3,11,7,15.
// - thirty-column reorder table as listed in the lookup below.
// - read column by column, delete dummies, frame bit count leaves.
// - bit zero maps to +1, bit one to -1.
// - random-access data on I with I code, pilot on Q with Q code.
// - each symbol becomes spreading-factor chips of its branch code.
// - I and Q chips form one complex stream times complex scrambling code.
// - random-access scrambling restarts at each frame start.
// - dedicated scrambling restarts at each frame start.
// - dedicated coded bits alternate onto I then Q.
// - dedicated unique word is sent whole on both I and Q.
// - code selections come from outside configuration, not fixed logic.
// - the same code may be set on both branches.
// - all dedicated channels of one carrier share one scrambling sequence.
// - first code chip is sent earliest.
// - scrambling code period is 256 chips.
module rlcis_top #(
  parameter int MAX_BITS = `RLCIS_MAX_BITS, // coded bits a frame may hold
  parameter int CHIP_DIV = `RLCIS_CHIP_DIV  // clocks per chip
) (
  input  wire logic              clk,         // 20 MHz clock
  input  wire logic              rst,         // async reset, high
  input  wire logic [1:0]        frame_type,  // frame kind, rlcis_frame_t
  input  wire logic              mobile_term, // terminal is mobile
  input  wire logic [3:0]        spreading_factor_log2, // log2 of spreading factor
  input  wire logic [7:0]        code_i,      // I branch code number
  input  wire logic [7:0]        code_q,      // Q branch code number
  input  wire logic [23:0]       scr_code,    // scrambling code number
  input  wire logic              in_valid,    // input bit offered
  input  wire logic              in_bit,      // information or unique word bit
  input  wire logic              in_perm_bit, // same bit after turbo internal interleaver
  input  wire logic              in_unique_word, // bit belongs to the unique word
  input  wire logic              in_last,     // last information bit of frame
  input  wire logic              pilot_bit,   // random-access pilot bit
  output logic                   in_ready,    // ready to accept an input bit this cycle
  output logic                   chip_valid,  // chip output valid
  output logic signed [2:0]      chip_i,      // scrambled chip, real part
  output logic signed [2:0]      chip_q,      // scrambled chip, imaginary part
  output logic                   frame_start, // first chip of a frame
  output logic                   frame_done   // frame fully sent
);
  localparam int AW = $clog2(MAX_BITS);
  localparam logic [4:0] P30 [30] = '{5'h00, 5'h14, 5'h0A, 5'h05, 5'h0F, 5'h19, 5'h03, 5'h0D,
    5'h17, 5'h08, 5'h12, 5'h1C, 5'h01, 5'h0B, 5'h15, 5'h06, 5'h10, 5'h1A, 5'h04, 5'h0E, 5'h18,
    5'h13, 5'h09, 5'h1D, 5'h0C, 5'h02, 5'h07, 5'h16, 5'h1B, 5'h11};
  localparam logic [4:0] P16 [16] = '{5'h00, 5'h08, 5'h04, 5'h0C, 5'h02, 5'h0A, 5'h06, 5'h0E,
    5'h01, 5'h09, 5'h05, 5'h0D, 5'h03, 5'h0B, 5'h07, 5'h0F};

  function automatic logic signed [2:0] pm(input logic b);
    return b ? 3'sh7 : 3'sh1;
  endfunction : pm

  function automatic logic [15:0] a_init(input logic [7:0] n);
    logic [15:0] a;
    a = 16'h0001;
    for (int k = 0; k < 8; k++) a[2*k+1] = n[k];
    return a;
  endfunction : a_init

  function automatic logic [7:0] rev8(input logic [7:0] v);
    logic [7:0] r;
    r = 8'h00;
    for (int k = 0; k < 8; k++) r[k] = v[7-k];
    return r;
  endfunction : rev8

  rlcis_pkg::rlcis_state_t st, next_st;
  logic [1:0]  ftype;
  logic        mob, open, rate13, ilv, acc, data, fin;
  logic [3:0]  spread_log2;
  logic [7:0]  ci_code, cq_code, sfm, chip_cnt, sidx;
  logic [23:0] scr;
  logic [4:0]  ncol, rcol, perm;
  logic        x1, p1, x2, p2, tail1;
  logic [2:0]  eb, tcnt;
  logic [1:0]  en, ei, q, qu, qn, pop;
  logic        kodd, last_seen;
  logic        mem [MAX_BITS];
  logic [AW:0] wptr, wrow, nrows, rrow, rbase, rcnt, paddr;
  logic [4:0]  wcol;
  logic [39:0] unique_word;
  logic [5:0]  word_len, word_rd;
  logic        word_src, cod_src, src_empty, hit, src_bit, fe;
  logic        ld, pair, uwsym, ld_q, si, sq, sym_ok, emit, fst;
  logic [15:0] sa, dcnt;
  logic [7:0]  sb, sd;
  logic [1:0]  z, anew;
  logic        c2h, c2e, c1b, ci_b, cq_b, w_b, tick;
  logic signed [2:0] re, im;

  assign rate13 = ftype == rlcis_pkg::FR_RA;
  assign ilv    = rate13 || (ftype == rlcis_pkg::FR_MOB && mob);
  assign ncol   = rate13 ? `RLCIS_COLS_THIRD : `RLCIS_COLS_HALF;
  assign acc    = in_ready && in_valid;
  assign data   = acc && !in_unique_word;
  assign tail1  = tcnt < `RLCIS_TERM_STEPS;

  ////////////////////////////////////////////////////////////////////////////
  // configuration is held for the whole frame once its first bit is taken
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      ftype   <= 2'h0;
      mob     <= 1'b0;
      spread_log2 <= 4'h0;
      ci_code <= 8'h00;
      cq_code <= 8'h00;
      scr     <= 24'h000000;
    end else if (st == rlcis_pkg::ST_LOAD && !open) begin
      ftype   <= frame_type;
      mob     <= mobile_term;
      spread_log2 <= spreading_factor_log2;
      ci_code <= code_i;
      cq_code <= code_q;
      scr     <= scr_code;
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      open <= 1'b0;
    end else if (fin) begin
      open <= 1'b0;
    end else if (acc) begin
      open <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // turbo encoder; the internal interleaver sits upstream
  rlcis_rsc u_enc1 (.clk(clk), .rst(rst), .clr(fin), .step(data || (st == rlcis_pkg::ST_TAIL
    && tail1)), .term(st == rlcis_pkg::ST_TAIL), .u(in_bit), .sys(x1), .par(p1));
  rlcis_rsc u_enc2 (.clk(clk), .rst(rst), .clr(fin), .step(data || (st == rlcis_pkg::ST_TAIL
    && !tail1)), .term(st == rlcis_pkg::ST_TAIL), .u(in_perm_bit), .sys(x2), .par(p2));

  always_comb begin
    next_st = st;
    case (st)
      rlcis_pkg::ST_LOAD: if (data) next_st = rlcis_pkg::ST_EMIT;
      rlcis_pkg::ST_EMIT: begin
        if (ei == en - 2'h1) begin
          if (!last_seen) next_st = rlcis_pkg::ST_LOAD;
          else if (tcnt == `RLCIS_TAIL_STEPS) next_st = rlcis_pkg::ST_SEND;
          else next_st = rlcis_pkg::ST_TAIL;
        end
      end
      rlcis_pkg::ST_TAIL: next_st = rlcis_pkg::ST_EMIT;
      rlcis_pkg::ST_SEND: if (fin) next_st = rlcis_pkg::ST_LOAD;
      default: next_st = rlcis_pkg::ST_LOAD;
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      st       <= rlcis_pkg::ST_LOAD;
      in_ready <= 1'b0;
    end else begin
      st       <= next_st;
      in_ready <= next_st == rlcis_pkg::ST_LOAD;
    end
  end

  // coded bits of one step are serialised into the frame store, msb first
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      eb        <= 3'h0;
      en        <= `RLCIS_BITS_HALF;
      ei        <= 2'h0;
      kodd      <= 1'b0;
      last_seen <= 1'b0;
      tcnt      <= 3'h0;
    end else if (fin) begin
      kodd      <= 1'b0;
      last_seen <= 1'b0;
      tcnt      <= 3'h0;
    end else if (data) begin
      ei        <= 2'h0;
      last_seen <= in_last;
      if (rate13) begin
        eb <= {in_bit, p1, p2};
        en <= `RLCIS_BITS_THIRD;
      end else begin
        eb   <= {in_bit, kodd ? p2 : p1, 1'b0};
        en   <= `RLCIS_BITS_HALF;
        kodd <= ~kodd;
      end
    end else if (st == rlcis_pkg::ST_TAIL) begin
      eb   <= {tail1 ? x1 : x2, tail1 ? p1 : p2, 1'b0};
      en   <= `RLCIS_BITS_HALF;
      ei   <= 2'h0;
      tcnt <= tcnt + 3'h1;
    end else if (st == rlcis_pkg::ST_EMIT) begin
      eb <= {eb[1:0], 1'b0};
      ei <= ei + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // frame store, written row by row; bits past MAX_BITS are lost
  always_ff @(posedge clk) begin
    if (st == rlcis_pkg::ST_EMIT && wptr < (AW+1)'(MAX_BITS)) begin
      mem[wptr[AW-1:0]] <= eb[2];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      wptr <= '0;
      wcol <= 5'h00;
      wrow <= '0;
    end else if (fin) begin
      wptr <= '0;
      wcol <= 5'h00;
      wrow <= '0;
    end else if (st == rlcis_pkg::ST_EMIT) begin
      wptr <= wptr + (AW+1)'(1);
      if (wcol == ncol - 5'h01) begin
        wcol <= 5'h00;
        wrow <= wrow + (AW+1)'(1);
      end else begin
        wcol <= wcol + 5'h01;
      end
    end
  end

  assign nrows = wrow + (AW+1)'(wcol != 5'h00);

  // unique word is kept aside from the coded bits
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      unique_word <= 40'h0;
      word_len    <= 6'h00;
    end else if (fin) begin
      word_len    <= 6'h00;
    end else if (acc && in_unique_word && word_len < `RLCIS_WORD_MAX) begin
      unique_word <= {unique_word[38:0], in_bit};
      word_len    <= word_len + 6'h01;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read side: unique word first, then coded bits, column by column when interleaved, in write order otherwise
  assign perm      = rate13 ? P30[rcol] : P16[rcol[3:0]];
  assign word_src  = word_rd < word_len;
  assign cod_src   = rcnt < wptr;
  assign src_empty = !word_src && !cod_src;
  assign paddr     = ilv ? rbase + (AW+1)'(perm) : rcnt;
  assign hit       = word_src || paddr < wptr;
  assign src_bit   = word_src ? unique_word[6'(word_len - 6'h01 - word_rd)] :
                     (paddr < wptr ? mem[paddr[AW-1:0]] : 1'b0);
  assign uwsym     = qn != 2'h0 && qu[0];
  assign pair      = qn == 2'h2 && !qu[0];
  assign ld        = st == rlcis_pkg::ST_SEND && !sym_ok && qn != 2'h0 &&
                     (rate13 || uwsym || pair || src_empty);
  assign pop       = !ld ? 2'h0 : (pair && !rate13 ? 2'h2 : 2'h1);
  assign fe        = st == rlcis_pkg::ST_SEND && !src_empty && pop == 2'h0 && qn != 2'h2;
  assign fin       = st == rlcis_pkg::ST_SEND && src_empty && qn == 2'h0 && !sym_ok;
  assign ld_q      = rate13 ? pilot_bit : (qu[0] ? q[0] : (pair ? q[1] : 1'b0));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      word_rd <= 6'h00;
      rcnt    <= '0;
      rrow    <= '0;
      rbase   <= '0;
      rcol    <= 5'h00;
    end else if (fin) begin
      word_rd <= 6'h00;
      rcnt    <= '0;
      rrow    <= '0;
      rbase   <= '0;
      rcol    <= 5'h00;
    end else if (fe && word_src) begin
      word_rd <= word_rd + 6'h01;
    end else if (fe) begin
      if (hit) rcnt <= rcnt + (AW+1)'(1);
      if (ilv && rrow == nrows - (AW+1)'(1)) begin
        rrow  <= '0;
        rbase <= '0;
        rcol  <= rcol + 5'h01;
      end else if (ilv) begin
        rrow  <= rrow + (AW+1)'(1);
        rbase <= rbase + (AW+1)'(ncol);
      end
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      q  <= 2'h0;
      qu <= 2'h0;
      qn <= 2'h0;
    end else if (fin || pop == 2'h2) begin
      qn <= 2'h0;
    end else if (pop == 2'h1) begin
      q[0]  <= q[1];
      qu[0] <= qu[1];
      qn    <= qn - 2'h1;
    end else if (fe && hit) begin
      q[qn[0]]  <= src_bit;
      qu[qn[0]] <= word_src;
      qn        <= qn + 2'h1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // chip divider, symbol holder and channelisation
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      dcnt <= 16'h0000;
      tick <= 1'b0;
    end else begin
      tick <= dcnt == 16'(CHIP_DIV - 1);
      dcnt <= dcnt == 16'(CHIP_DIV - 1) ? 16'h0000 : dcnt + 16'h0001;
    end
  end

  assign sfm  = 8'((9'h001 << spread_log2) - 9'h001);
  assign emit = tick && sym_ok;
  assign ci_b = si ^ (^(chip_cnt & (rev8(ci_code) >> (4'h8 - spread_log2))));
  assign cq_b = sq ^ (^(chip_cnt & (rev8(cq_code) >> (4'h8 - spread_log2))));

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      si       <= 1'b0;
      sq       <= 1'b0;
      sym_ok   <= 1'b0;
      chip_cnt <= 8'h00;
    end else if (ld) begin
      si     <= q[0];
      sq     <= ld_q;
      sym_ok <= 1'b1;
    end else if (emit) begin
      chip_cnt <= chip_cnt == sfm ? 8'h00 : chip_cnt + 8'h01;
      if (chip_cnt == sfm) sym_ok <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // scrambler: 255-chip sequence plus z(255) = z(0), held at start outside frames
  assign z    = sidx == `RLCIS_SCR_LAST ? {scr[0] ^ scr[8] ^ scr[16], 1'b1} :
                {sa[1] ^ sb[0] ^ sd[0], sa[0]};
  assign anew = 2'(2'h3 * sa[11:10] + sa[7:6] + 2'h3 * sa[5:4] + 2'h2 * sa[3:2] +
                2'h3 * sa[1:0]);
  assign c1b  = z[1] ^ z[0];
  assign c2e  = sidx[0] ? c2h : z[1];
  assign w_b  = c2e ^ sidx[0];
  assign re   = pm(ci_b) - pm(cq_b ^ w_b);
  assign im   = pm(cq_b) + pm(ci_b ^ w_b);

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      sa   <= 16'h0001;
      sb   <= 8'h00;
      sd   <= 8'h00;
      sidx <= 8'h00;
      c2h  <= 1'b0;
    end else if (st != rlcis_pkg::ST_SEND || sidx == `RLCIS_SCR_LAST && emit) begin
      sa   <= a_init(scr[7:0]);
      sb   <= scr[15:8];
      sd   <= scr[23:16];
      sidx <= st != rlcis_pkg::ST_SEND ? 8'h00 : sidx + 8'h01;
    end else if (emit) begin
      sa   <= {anew, sa[15:2]};
      sb   <= {sb[7] ^ sb[5] ^ sb[1] ^ sb[0], sb[7:1]};
      sd   <= {sd[7] ^ sd[5] ^ sd[4] ^ sd[0], sd[7:1]};
      sidx <= sidx + 8'h01;
      c2h  <= z[1];
    end
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      chip_valid  <= 1'b0;
      chip_i      <= 3'sh0;
      chip_q      <= 3'sh0;
      frame_start <= 1'b0;
      frame_done  <= 1'b0;
      fst         <= 1'b1;
    end else begin
      chip_valid  <= emit;
      chip_i      <= c1b ? -re : re;
      chip_q      <= c1b ? -im : im;
      frame_start <= emit && fst;
      frame_done  <= fin;
      if (fin) fst <= 1'b1;
      else if (emit) fst <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  ra_rate_a: assert property (data && rate13 |=> en == 2'h3 ##2 ei == 2'h2)
    else $error("rate one third step not three bits");
  ded_rate_a: assert property (data && !rate13 |=> en == 2'h2 ##1 ei == 2'h1)
    else $error("dedicated step not two bits");
  punct_sel_a: assert property (data && !rate13 |=> eb[1] == ($past(kodd) ? $past(p2) :
    $past(p1))) else $error("wrong parity kept");
  tail_pass_a: assert property (st == rlcis_pkg::ST_TAIL |=> en == 2'h2 &&
    st == rlcis_pkg::ST_EMIT) else $error("tail step punctured");
  ilv_sel_a: assert property (fe && !word_src && !ilv |-> paddr == rcnt)
    else $error("bypass frame reordered");
  word_skip_a: assert property (acc && in_unique_word |=> $stable(wptr) ##1 $stable(wptr))
    else $error("unique word entered coded store");
  col_wrap_a: assert property (st == rlcis_pkg::ST_EMIT && wcol == ncol - 5'h01 |=>
    wcol == 5'h00) else $error("column count wrong");
  row_cnt_a: assert property (st == rlcis_pkg::ST_SEND && wptr != '0 |->
    int'(nrows) * int'(ncol) >= int'(wptr) && (int'(nrows) - 1) * int'(ncol) < int'(wptr))
    else $error("row count not minimal");
  fill_a: assert property (st == rlcis_pkg::ST_EMIT && wptr < (AW+1)'(MAX_BITS) |=>
    wptr == $past(wptr) + 1'b1) else $error("store not filled in order");
  perm_col_a: assert property (fe && ilv && !word_src |->
    int'(paddr) % int'(ncol) == int'(perm)) else $error("column reorder wrong");
  prune_a: assert property (fin |-> rcnt == wptr)
    else $error("pruned count differs from frame");
  pilot_q_a: assert property (ld && rate13 |=> sq == $past(pilot_bit) && si == $past(q[0]))
    else $error("pilot not on Q");
  sf_len_a: assert property (emit && chip_cnt == sfm |=> chip_cnt == 8'h00)
    else $error("symbol length not spreading factor");
  scr_align_a: assert property ($rose(st == rlcis_pkg::ST_SEND) |-> sidx == 8'h00 && fst)
    else $error("scrambler not restarted at frame");
  pair_a: assert property (ld && !rate13 && pair |=> si == $past(q[0]) &&
    sq == $past(q[1])) else $error("dedicated pair split wrong");
  word_both_a: assert property (ld && !rate13 && qu[0] |=> si == sq)
    else $error("unique word not on both branches");
  scr_wrap_a: assert property (emit && sidx == `RLCIS_SCR_LAST |=> sidx == 8'h00)
    else $error("scrambling period not 256");
endmodule : rlcis_top

// ==== pkg/rlcis_params.svh ====
// rlcis_params.svh: constants for the return-link coding, interleaving and spreading chain
`ifndef RLCIS_PARAMS_SVH
`define RLCIS_PARAMS_SVH
`define RLCIS_COLS_THIRD 5'h1E
`define RLCIS_COLS_HALF  5'h10
`define RLCIS_BITS_THIRD 2'h3
`define RLCIS_BITS_HALF  2'h2
`define RLCIS_TERM_STEPS 3'h3
`define RLCIS_TAIL_STEPS 3'h6
`define RLCIS_WORD_MAX   6'h28
`define RLCIS_SCR_LAST   8'hFF
`define RLCIS_MAX_BITS   32'h4000
`define RLCIS_CHIP_DIV   32'h5
`endif

// ==== pkg/rlcis_pkg.sv ====
// rlcis_pkg: state and frame-type enumerations of the return-link chain
package rlcis_pkg;
  typedef enum logic [1:0] {
    ST_LOAD = 2'h0,
    ST_EMIT = 2'h1,
    ST_TAIL = 2'h3,
    ST_SEND = 2'h2
  } rlcis_state_t;
  typedef enum logic [1:0] {
    FR_RA  = 2'h0,
    FR_DED = 2'h1,
    FR_MOB = 2'h2
  } rlcis_frame_t;
endpackage : rlcis_pkg

// ==== rtl/rlcis_rsc.sv ====
// rlcis_rsc: one 8-state recursive systematic constituent encoder with trellis termination
`timescale 1ns/1ns
module rlcis_rsc (
  input  wire logic clk,  // sample clock
  input  wire logic rst,  // async reset, high
  input  wire logic clr,  // return to zero state
  input  wire logic step, // advance one trellis step
  input  wire logic term, // termination step: input is the feedback
  input  wire logic u,    // information bit
  output logic      sys,  // systematic bit of this step
  output logic      par   // parity bit of this step
);
  logic [2:0] s;
  logic       fb;
  logic       w;

  // feedback 1+D2+D3, parity 1+D+D3
  assign fb  = s[1] ^ s[2];
  assign w   = term ? 1'b0 : (u ^ fb);
  assign sys = term ? fb : u;
  assign par = w ^ s[0] ^ s[2];

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      s <= 3'h0;
    end else if (clr) begin
      s <= 3'h0;
    end else if (step) begin
      s <= {s[1:0], w};
    end
  end
endmodule : rlcis_rsc

// ==== tb/rlcis_feeder.sv ====
// rlcis_feeder: frame builder model offering unique word and information bits
`timescale 1ns/1ns
module rlcis_feeder (
  input  wire logic clk,   // clock
  input  wire logic rdy,   // ready seen from the chain
  output logic      vld,   // bit offered
  output logic      bit_o, // information or unique word bit
  output logic      perm,  // bit after the turbo internal interleaver
  output logic      word_flag, // unique word flag
  output logic      last   // last information bit
);
  initial {vld, bit_o, perm, word_flag, last} = 5'h00;
  ////////////////////////////////////////
  // request held from just after an edge until the edge that samples ready high
  task automatic put(input logic b, input logic u, input logic l, input int gap);
    if (gap > 0) begin
      vld = 1'b0;
      // released lines keep moving so a stale value is never mistaken for data
      repeat (gap) begin
        {bit_o, perm, word_flag, last} = ~{bit_o, perm, word_flag, last};
        @(posedge clk);
        #5;
      end
    end
    vld = 1'b1;
    bit_o = b;
    perm = ~b;
    word_flag = u;
    last = l;
    do @(negedge clk); while (rdy !== 1'b1);
    @(posedge clk);
    #5;
  endtask : put
  task automatic idle();
    vld = 1'b0;
  endtask : idle
endmodule : rlcis_feeder

// ==== tb/tb_top.sv ====
// tb_top: self-checking bench for the return-link coding and spreading chain
`timescale 1ns/1ns
module tb_top;
  typedef struct {
    logic [1:0] ft; logic mob; logic [7:0] ci; logic [7:0] cq; logic [23:0] scr;
    int ni; logic [31:0] info; int gap;
  } rlcis_row_t;
  localparam logic [3:0] WORD = 4'hB;
  logic              clk, rst, mob, vld, bi, pb, word_flag, last, rdy, cv, fs, fd, pil;
  logic [1:0]        ft;
  logic [7:0]        ci, cq;
  logic [23:0]       scr;
  logic signed [2:0] chi, chq;
  int                n_errors = 0, n_compared = 0, cidx = 0, nfd = 0, lsf = 2, nchip = 4;
  int                zt[256];
  logic              si[$], sq[$];
  int p30[30] = '{0, 20, 10, 5, 15, 25, 3, 13, 23, 8, 18, 28, 1, 11, 21, 6, 16, 26, 4, 14,
                  24, 19, 9, 29, 12, 2, 7, 22, 27, 17};
  int p16[16] = '{0, 8, 4, 12, 2, 10, 6, 14, 1, 9, 5, 13, 3, 11, 7, 15};
  rlcis_row_t rows[5] = '{'{2'h0, 1'b0, 8'h01, 8'h02, 24'h000000, 24, 32'h00C3A55A, 0},
                          '{2'h1, 1'b0, 8'h03, 8'h03, 24'h123456, 5, 32'h00000016, 1},
                          '{2'h2, 1'b1, 8'h02, 8'h01, 24'hABCDEF, 6, 32'h0000002D, 0},
                          '{2'h2, 1'b0, 8'h00, 8'h03, 24'h0F0F0F, 3, 32'h00000005, 0},
                          '{2'h3, 1'b0, 8'h01, 8'h00, 24'hFEDCBA, 2, 32'h00000002, 2}};
  rlcis_top #(.MAX_BITS(512), .CHIP_DIV(2)) i_rlcis_top (.clk(clk), .rst(rst),
    .frame_type(ft), .mobile_term(mob), .spreading_factor_log2(4'(lsf)), .code_i(ci),
    .code_q(cq), .scr_code(scr), .in_valid(vld), .in_bit(bi), .in_perm_bit(pb),
    .in_unique_word(word_flag), .in_last(last), .pilot_bit(pil), .in_ready(rdy),
    .chip_valid(cv), .chip_i(chi), .chip_q(chq), .frame_start(fs), .frame_done(fd));
  rlcis_feeder i_rlcis_feeder (.clk(clk), .rdy(rdy), .vld(vld), .bit_o(bi), .perm(pb),
    .word_flag(word_flag), .last(last));
  // pilot follows symbol parity: a symbol loads only after the previous one's chips are counted
  assign pil = (cidx / nchip) % 2 == 1;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  ////////////////////////////////////////
  task automatic chk(input logic ok, input string m);
    n_compared++;
    if (ok !== 1'b1) begin
      n_errors++;
      $display("mismatch at %0t: %s", $time, m);
    end
  endtask : chk
  task automatic build_scr(input logic [23:0] nn);
    int a[255], b[255], d[255];
    for (int i = 0; i < 255; i++) begin
      if (i < 8) begin
        a[i] = (2 * nn[i] + (i == 0)) % 4;
        b[i] = nn[8 + i];
        d[i] = nn[16 + i];
      end else begin
        a[i] = (3 * a[i-3] + a[i-5] + 3 * a[i-6] + 2 * a[i-7] + 3 * a[i-8]) % 4;
        b[i] = b[i-1] ^ b[i-3] ^ b[i-7] ^ b[i-8];
        d[i] = d[i-1] ^ d[i-3] ^ d[i-4] ^ d[i-8];
      end
      zt[i] = (a[i] + 2 * b[i] + 2 * d[i]) % 4;
    end
    zt[255] = zt[0];
  endtask : build_scr
  function automatic logic [5:0] exp_chip(input int c);
    int i, s, n, di, dq, c1, c2, w, ri, rq;
    logic signed [2:0] ei, eq;
    i = c % 256;
    s = c / nchip;
    n = c % nchip;
    if (s >= si.size()) return 6'h24;
    ri = 0;
    rq = 0;
    // chip n of code k is negative when n and bit-reversed k share an odd count of ones
    for (int b = 0; b < lsf; b++) begin
      ri |= int'(ci[b]) << (lsf - 1 - b);
      rq |= int'(cq[b]) << (lsf - 1 - b);
    end
    di = (si[s] ? -1 : 1) * (($countones(n & ri) % 2) ? -1 : 1);
    dq = (sq[s] ? -1 : 1) * (($countones(n & rq) % 2) ? -1 : 1);
    c1 = (zt[i] == 1 || zt[i] == 2) ? -1 : 1;
    c2 = (zt[2 * (i / 2)] >= 2) ? -1 : 1;
    w = i[0] ? -1 : 1;
    ei = 3'(c1 * (di - w * c2 * dq));
    eq = 3'(c1 * (dq + w * c2 * di));
    return {ei, eq};
  endfunction : exp_chip
  // one constituent encoder step, returns {systematic, parity}
  function automatic logic [1:0] rsc(inout logic [2:0] s, input logic u, input logic t);
    logic a, x;
    x = t ? (s[1] ^ s[2]) : u;
    a = x ^ s[1] ^ s[2];
    rsc = {x, a ^ s[0] ^ s[2]};
    s = {s[1:0], a};
  endfunction : rsc
  ////////////////////////////////////////
  always @(negedge clk) begin
    if (fd === 1'b1) nfd++;
    if (cv === 1'b1) begin
      chk(fs === (cidx == 0), "frame start flag");
      chk({chi, chq} === exp_chip(cidx), "chip value");
      cidx++;
    end
  end
  task automatic run_row(input rlcis_row_t r);
    logic [2:0] s1, s2;
    logic [1:0] o1, o2;
    logic cb[$], v[$];
    int nc, rr, ix;
    logic ra;
    ra = (r.ft == 2'h0);
    s1 = 3'h0;
    s2 = 3'h0;
    for (int k = 0; k < r.ni; k++) begin
      o1 = rsc(s1, r.info[k], 1'b0);
      o2 = rsc(s2, ~r.info[k], 1'b0);
      cb.push_back(o1[1]);
      if (ra || k % 2 == 0) cb.push_back(o1[0]);
      if (ra || k % 2 == 1) cb.push_back(o2[0]);
    end
    for (int k = 0; k < 6; k++) begin
      o1 = (k < 3) ? rsc(s1, 1'b0, 1'b1) : rsc(s2, 1'b0, 1'b1);
      cb.push_back(o1[1]);
      cb.push_back(o1[0]);
    end
    nc = ra ? 30 : 16;
    if (ra || (r.ft == 2'h2 && r.mob)) begin
      rr = (cb.size() + nc - 1) / nc;
      for (int j = 0; j < nc; j++)
        for (int q = 0; q < rr; q++) begin
          ix = q * nc + (ra ? p30[j] : p16[j]);
          if (ix < cb.size()) v.push_back(cb[ix]);
        end
    end else v = cb;
    si = {};
    sq = {};
    for (int k = 0; k < 4; k++) begin
      si.push_back(WORD[3-k]);
      sq.push_back(ra ? sq.size() % 2 == 1 : WORD[3-k]);
    end
    for (int k = 0; k < v.size(); k += ra ? 1 : 2) begin
      si.push_back(v[k]);
      sq.push_back(ra ? sq.size() % 2 == 1 : v[k + 1]);
    end
    build_scr(r.scr);
    {ft, mob, ci, cq, scr} = {r.ft, r.mob, r.ci, r.cq, r.scr};
    lsf = (r.ft == 2'h0) ? 2 : 3;
    nchip = 1 << lsf;
    cidx = 0;
    nfd = 0;
    for (int k = 0; k < 4; k++) i_rlcis_feeder.put(WORD[3-k], 1'b1, 1'b0, r.gap);
    for (int k = 0; k < r.ni; k++) i_rlcis_feeder.put(r.info[k], 1'b0, k == r.ni - 1, r.gap);
    i_rlcis_feeder.idle();
    for (int t = 0; t < 4000 && nfd == 0; t++) @(posedge clk);
    repeat (4) @(posedge clk);
    #5;
    chk(cidx == nchip * si.size() && nfd == 1, "chip count");
  endtask : run_row
  task automatic do_reset(input int n);
    rst = 1'b1;
    repeat (n) @(posedge clk);
    #5;
    chk({rdy, cv, fs, fd, chi, chq} === 10'h000, "outputs held in reset");
    rst = 1'b0;
    repeat (2) @(posedge clk);
    #5;
    chk(rdy === 1'b1, "ready after reset");
  endtask : do_reset
  task automatic complete_run();
    $display("compared %0d, mismatches %0d", n_compared, n_errors);
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : complete_run
  ////////////////////////////////////////
  initial begin
    {ft, mob, ci, cq, scr} = '0;
    do_reset(16);
    foreach (rows[r]) begin
      run_row(rows[r]);
      $display("test row %0d done", r);
    end
    // reset lands while chips of a long frame are still leaving
    fork
      run_row(rows[0]);
    join_none
    repeat (300) @(posedge clk);
    #5;
    disable fork;
    i_rlcis_feeder.idle();
    do_reset(2);
    run_row(rows[1]);
    $display("test reset in mid frame done");
    complete_run();
  end
  initial begin
    #(50 * 20000);
    n_errors++;
    $display("mismatch at %0t: run timed out", $time);
    complete_run();
  end
endmodule : tb_top
